// >>> hdl/gpio_lock_consts.svh
// constants for the port configuration lock and alternate-function block
// assumes inclusion by bare name from package and modules
`ifndef GPIO_LOCK_CONSTS_SVH
`define GPIO_LOCK_CONSTS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OFF_PIN_MODE 8'h00
`define OFF_OUTPUT_TYPE 8'h04
`define OFF_SLEW_RATE 8'h08
`define OFF_PULL_SELECT 8'h0C
`define OFF_DRIVE_STRENGTH 8'h24
`define OFF_CONFIG_LOCK 8'h1C
`define OFF_ALTFUNC_LOW 8'h20
`define OFF_ALTFUNC_HIGH 8'h28
`define OFF_PIN_INPUT 8'h10

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define LOCK_KEY_POS 16
`define PIN_COUNT 16
`define AF_WIDTH 4
`define RST_PIN_MODE 32'hFFFFFFFF
`define RST_ZERO 32'h00000000
`define RST_ZERO16 16'h0000
`define RST_SLEW 16'hFFFF

// ----------------------------------------
// alternate-function codes
// ----------------------------------------
`define AF_DEBUG 4'h0
`define AF_EVENT 4'h4
`define AF_COMP2 4'h8
`define AF_CODE9 4'h9
`define AF_COMP3_A 4'hA
`define AF_COMP3_B 4'hB
`define AF_BUZZER 4'hC

`endif

// >>> hdl/gpio_lock_pkg.sv
// types shared by the lock block
// assumes the constants header is on the include path
`include "gpio_lock_consts.svh"

package gpio_lock_pkg;
    typedef enum logic [1:0]
    {
        ARM_IDLE = 2'b00,
        ARM_SAW_ONE = 2'b01,
        ARM_SAW_ZERO = 2'b10,
        ARM_SAW_ONE_AGAIN = 2'b11
    } arm_state_e;
    typedef logic [`PIN_COUNT-1:0] pin_mask_t;
endpackage

// >>> hdl/lock_key_arm.sv
// arming sequencer for the lock key bit and per-pin lock bits
// assumes one-cycle strobes on the same clock
`default_nettype none
`timescale 1ns/1ps
`include "gpio_lock_consts.svh"

module lock_key_arm
    import gpio_lock_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic lock_wr,
    input wire logic lock_rd,
    input wire logic [31:0] wdata,
    output logic lock_key_bit,
    output pin_mask_t per_pin_lock_bits
);
    arm_state_e state;
    arm_state_e next_state;
    wire logic key_in = wdata[`LOCK_KEY_POS];
    wire pin_mask_t pins_in = wdata[`PIN_COUNT-1:0];
    wire logic same_pins = pins_in == per_pin_lock_bits;
    wire logic arm_done = lock_rd && state == ARM_SAW_ONE_AGAIN;

    // ----------------------------------------
    // sequence w1 w0 w1 r0
    // ----------------------------------------
    always_comb
    begin
        next_state = ARM_IDLE;
        case (state)
            ARM_IDLE:
                if (lock_wr && key_in)
                    next_state = ARM_SAW_ONE;
            ARM_SAW_ONE:
                if (lock_wr && !key_in && same_pins)
                    next_state = ARM_SAW_ZERO;
                else if (lock_wr && key_in)
                    next_state = ARM_SAW_ONE;
            ARM_SAW_ZERO:
                if (lock_wr && key_in && same_pins)
                    next_state = ARM_SAW_ONE_AGAIN;
                else if (lock_wr && key_in)
                    next_state = ARM_SAW_ONE;
            ARM_SAW_ONE_AGAIN:
                if (lock_wr && key_in)
                    next_state = ARM_SAW_ONE;
            default:
                next_state = ARM_IDLE;
        endcase
        if (lock_key_bit)
            next_state = ARM_IDLE;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= ARM_IDLE;
            lock_key_bit <= 1'b0;
            per_pin_lock_bits <= '0;
        end
        else
        begin
            state <= next_state;
            if (arm_done)
                lock_key_bit <= 1'b1;
            if (lock_wr && !lock_key_bit)
                per_pin_lock_bits <= pins_in;
        end
    end
endmodule
`default_nettype wire

// >>> hdl/altfunc_route.sv
// per-pin alternate-function output routing for one port
// assumes af codes come from the lock-guarded select registers
`default_nettype none
`timescale 1ns/1ps
`include "gpio_lock_consts.svh"

module altfunc_route
(
    input wire logic [1:0] port_id,
    input wire logic [63:0] af_codes,
    input wire logic core_event_output,
    input wire logic second_comparator_out,
    input wire logic third_comparator_out,
    input wire logic buzzer_positive_out,
    input wire logic buzzer_negative_out,
    input wire logic clock_output_pin,
    input wire logic debug_data_out,
    input wire logic test_data_out,
    output logic [15:0] af_out,
    output logic [15:0] af_valid
);
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1)
        begin : g_pin
            wire logic [3:0] c = af_codes[4*i +: 4];
            wire logic pa = port_id == 2'd0;
            wire logic pb = port_id == 2'd1;
            wire logic pc = port_id == 2'd2;
            wire logic pd = port_id == 2'd3;
            wire logic ev_ok = pa || pb || (pc && i == 13)
                || (pd && (i == 12 || i == 13));
            wire logic c2_ok = (pa && (i == 2 || i == 6 || i == 7
                || i == 12)) || (pb && i == 9);
            wire logic c2b_ok = pa && i == 14;
            wire logic c3_ok = pa && (i == 6 || i == 8 || i == 10);
            wire logic c3b_ok = pb && (i == 4 || i == 10);
            wire logic bz_ok = (pa || pb) && (i == 6 || i == 7);
            wire logic mco_ok = pa && (i == 8 || i == 9);
            wire logic dbg_ok = (pa && i == 13) || (pb && i == 3);
            wire logic ev_s = c == `AF_EVENT && ev_ok;
            wire logic c2_s = (c == `AF_COMP2 && c2_ok)
                || (c == `AF_CODE9 && c2b_ok);
            wire logic c3_s = (c == `AF_COMP3_A && c3_ok)
                || (c == `AF_COMP3_B && c3b_ok);
            wire logic bz_s = c == `AF_BUZZER && bz_ok;
            wire logic mco_s = c == `AF_CODE9 && mco_ok;
            wire logic dbg_s = c == `AF_DEBUG && dbg_ok;
            wire logic bz_v = (i == 6) ? buzzer_positive_out
                : buzzer_negative_out;
            wire logic dbg_v = (pa) ? debug_data_out : test_data_out;
            assign af_out[i] = ev_s ? core_event_output
                : c2_s ? second_comparator_out
                : c3_s ? third_comparator_out
                : bz_s ? bz_v
                : mco_s ? clock_output_pin
                : dbg_s ? dbg_v : 1'b0;
            assign af_valid[i] = ev_s | c2_s | c3_s | bz_s | mco_s | dbg_s;
        end
    endgenerate
endmodule
`default_nettype wire

// >>> hdl/gpio_config_lock_altfunc.sv
// port configuration registers with lock logic and alternate functions
// assumes a single-cycle strobe register port on clk, reset_n async low
//
// Operation
// - lock covers mode, type, pull, drive, slew and both af selects
// - locked pin configuration stays unchanged until next reset
// - key bit 16 sets only after write 1, write 0, write 1, read
// - key bit clears only by system reset
// - per-pin lock bits writable only while key is zero
// - pin lock value change during sequence aborts arming
// - key zero: all writable; key set: unlocked pins writable
// - field rejects writes only when key and pin lock both set
// - af4 routes core event output to listed pins
// - af0 connects the debug port pins
// - second comparator on af8 pins and af9 on pa14
// - third comparator on af10 and af11 pins
// - af12 routes buzzer outputs to pa6 pb6 pa7 pb7
// - af9 routes calendar_stamp_input input from pc13 to pc15
// - af9 routes clock output to pa8 or pa9
//
// Decided for this implementation: the plain strobed port and the register offsets.
`default_nettype none
`timescale 1ns/1ps
`include "gpio_lock_consts.svh"

module gpio_config_lock_altfunc
    import gpio_lock_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [1:0] port_id,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [15:0] pin_in,
    input wire logic core_event_output,
    input wire logic second_comparator_out,
    input wire logic third_comparator_out,
    input wire logic buzzer_positive_out,
    input wire logic buzzer_negative_out,
    input wire logic clock_output_pin,
    input wire logic debug_data_out,
    input wire logic test_data_out,
    output logic [15:0] af_out,
    output logic [15:0] af_valid,
    output logic calendar_stamp_input,
    output logic debug_mode_in,
    output logic debug_clock_in,
    output logic debug_data_in,
    output logic test_reset_n,
    output logic [31:0] pin_mode_reg,
    output logic [15:0] output_type_reg,
    output logic [15:0] slew_rate_reg,
    output logic [31:0] pull_select_reg,
    output logic [15:0] drive_strength_reg,
    output logic [31:0] altfunc_low_select,
    output logic [31:0] altfunc_high_select
);
    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire logic sel_mode = addr == `OFF_PIN_MODE;
    wire logic sel_otype = addr == `OFF_OUTPUT_TYPE;
    wire logic sel_slew = addr == `OFF_SLEW_RATE;
    wire logic sel_pull = addr == `OFF_PULL_SELECT;
    wire logic sel_drive = addr == `OFF_DRIVE_STRENGTH;
    wire logic sel_lock = addr == `OFF_CONFIG_LOCK;
    wire logic sel_afl = addr == `OFF_ALTFUNC_LOW;
    wire logic sel_afh = addr == `OFF_ALTFUNC_HIGH;
    wire logic sel_pin = addr == `OFF_PIN_INPUT;
    wire logic lock_wr = wr && sel_lock;
    wire logic lock_rd = rd && sel_lock;

    logic lock_key_bit;
    pin_mask_t per_pin_lock_bits;

    lock_key_arm u_arm
    (
        .clk(clk),
        .reset_n(reset_n),
        .lock_wr(lock_wr),
        .lock_rd(lock_rd),
        .wdata(wdata),
        .lock_key_bit(lock_key_bit),
        .per_pin_lock_bits(per_pin_lock_bits)
    );

    // ----------------------------------------
    // write masks from lock state
    // ----------------------------------------
    wire pin_mask_t frozen = lock_key_bit ? per_pin_lock_bits : '0;
    logic [15:0] m1;
    logic [31:0] m2;
    logic [63:0] m4;
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1)
        begin : g_mask
            assign m1[i] = ~frozen[i];
            assign m2[2*i +: 2] = {2{~frozen[i]}};
            assign m4[4*i +: 4] = {4{~frozen[i]}};
        end
    endgenerate

    // merge keeps locked bits, takes unlocked ones
    wire logic [31:0] next_mode = (pin_mode_reg & ~m2) | (wdata & m2);
    wire logic [31:0] next_pull = (pull_select_reg & ~m2) | (wdata & m2);
    wire logic [15:0] next_otype =
        (output_type_reg & ~m1) | (wdata[15:0] & m1);
    wire logic [15:0] next_slew = (slew_rate_reg & ~m1) | (wdata[15:0] & m1);
    wire logic [15:0] next_drive =
        (drive_strength_reg & ~m1) | (wdata[15:0] & m1);
    wire logic [31:0] next_afl =
        (altfunc_low_select & ~m4[31:0]) | (wdata & m4[31:0]);
    wire logic [31:0] next_afh =
        (altfunc_high_select & ~m4[63:32]) | (wdata & m4[63:32]);

    // ----------------------------------------
    // write enables
    // ----------------------------------------
    wire logic wr_mode = wr && sel_mode;
    wire logic wr_otype = wr && sel_otype;
    wire logic wr_slew = wr && sel_slew;
    wire logic wr_pull = wr && sel_pull;
    wire logic wr_drive = wr && sel_drive;
    wire logic wr_afl = wr && sel_afl;
    wire logic wr_afh = wr && sel_afh;

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            pin_mode_reg <= `RST_PIN_MODE;
        else if (wr_mode)
            pin_mode_reg <= next_mode;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            output_type_reg <= `RST_ZERO16;
        else if (wr_otype)
            output_type_reg <= next_otype;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            slew_rate_reg <= `RST_SLEW;
        else if (wr_slew)
            slew_rate_reg <= next_slew;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            pull_select_reg <= `RST_ZERO;
        else if (wr_pull)
            pull_select_reg <= next_pull;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            drive_strength_reg <= `RST_ZERO16;
        else if (wr_drive)
            drive_strength_reg <= next_drive;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            altfunc_low_select <= `RST_ZERO;
        else if (wr_afl)
            altfunc_low_select <= next_afl;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            altfunc_high_select <= `RST_ZERO;
        else if (wr_afh)
            altfunc_high_select <= next_afh;
    end

    // ----------------------------------------
    // pin input synchroniser, 3 stages
    // ----------------------------------------
    logic [15:0] pin_s1;
    logic [15:0] pin_s2;
    logic [15:0] pin_s3;
    logic [15:0] pin_stable;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_s1 <= 16'h0000;
            pin_s2 <= 16'h0000;
            pin_s3 <= 16'h0000;
            pin_stable <= 16'h0000;
        end
        else
        begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_stable <= (pin_stable & ~(pin_s2 ^ pin_s3))
                | (pin_s2 & ~(pin_s2 ^ pin_s3));
        end
    end

    // ----------------------------------------
    // alternate-function inputs
    // ----------------------------------------
    wire logic [63:0] af_codes = {altfunc_high_select, altfunc_low_select};
    wire logic is_pa = port_id == 2'd0;
    wire logic is_pb = port_id == 2'd1;
    wire logic is_pc = port_id == 2'd2;
    wire logic stamp_sel = is_pc && ((af_codes[52 +: 4] == `AF_CODE9)
        || (af_codes[56 +: 4] == `AF_CODE9)
        || (af_codes[60 +: 4] == `AF_CODE9));
    wire logic stamp_val =
        (af_codes[52 +: 4] == `AF_CODE9 && pin_stable[13])
        || (af_codes[56 +: 4] == `AF_CODE9 && pin_stable[14])
        || (af_codes[60 +: 4] == `AF_CODE9 && pin_stable[15]);
    wire logic dbg_mode = is_pa && af_codes[52 +: 4] == `AF_DEBUG;
    wire logic dbg_clk = is_pa && af_codes[56 +: 4] == `AF_DEBUG;
    wire logic dbg_tdi = is_pa && af_codes[60 +: 4] == `AF_DEBUG;
    wire logic dbg_rst = is_pb && af_codes[16 +: 4] == `AF_DEBUG;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            calendar_stamp_input <= 1'b0;
        else
            calendar_stamp_input <= stamp_sel && stamp_val;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            debug_mode_in <= 1'b1;
            debug_clock_in <= 1'b0;
            debug_data_in <= 1'b1;
            test_reset_n <= 1'b1;
        end
        else
        begin
            debug_mode_in <= dbg_mode ? pin_stable[13] : 1'b1;
            debug_clock_in <= dbg_clk ? pin_stable[14] : 1'b0;
            debug_data_in <= dbg_tdi ? pin_stable[15] : 1'b1;
            test_reset_n <= dbg_rst ? pin_stable[4] : 1'b1;
        end
    end

    altfunc_route u_route
    (
        .port_id(port_id),
        .af_codes(af_codes),
        .core_event_output(core_event_output),
        .second_comparator_out(second_comparator_out),
        .third_comparator_out(third_comparator_out),
        .buzzer_positive_out(buzzer_positive_out),
        .buzzer_negative_out(buzzer_negative_out),
        .clock_output_pin(clock_output_pin),
        .debug_data_out(debug_data_out),
        .test_data_out(test_data_out),
        .af_out(af_out),
        .af_valid(af_valid)
    );

    // ----------------------------------------
    // read path
    // ----------------------------------------
    wire logic [31:0] lock_view =
        {15'h0000, lock_key_bit, per_pin_lock_bits};
    wire logic [31:0] read_mux =
        sel_mode ? pin_mode_reg
        : sel_otype ? {16'h0000, output_type_reg}
        : sel_slew ? {16'h0000, slew_rate_reg}
        : sel_pull ? pull_select_reg
        : sel_drive ? {16'h0000, drive_strength_reg}
        : sel_lock ? lock_view
        : sel_afl ? altfunc_low_select
        : sel_afh ? altfunc_high_select
        : sel_pin ? {16'h0000, pin_stable}
        : 32'h00000000;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata <= 32'h00000000;
        else if (rd)
            rdata <= read_mux;
        else
            rdata <= 32'h00000000;
    end
endmodule
`default_nettype wire

// >>> test/gpio_lock_checker.sv
// assertions on the port lock block, ports only
// assumes bind to the top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "gpio_lock_consts.svh"

module gpio_lock_checker
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [1:0] port_id,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic core_event_output,
    input wire logic second_comparator_out,
    input wire logic buzzer_positive_out,
    input wire logic [15:0] af_out,
    input wire logic [15:0] af_valid,
    input wire logic [31:0] pin_mode_reg,
    input wire logic [15:0] output_type_reg,
    input wire logic [31:0] altfunc_low_select
);
    // ----------------------------------------
    // key tracking from lock reads
    // ----------------------------------------
    logic touched;
    logic key_seen;
    logic lock_rd;
    logic [15:0] held;
    logic [31:0] m2;
    wire lock_acc = addr == `OFF_CONFIG_LOCK;
    wire on_a = port_id == 2'h0;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            touched <= 1'b0;
            key_seen <= 1'b0;
            lock_rd <= 1'b0;
            held <= 16'h0;
        end
        else
        begin
            lock_rd <= rd && lock_acc;
            if (wr && lock_acc)
                touched <= 1'b1;
            if (lock_rd && rdata[16] && !key_seen)
            begin
                key_seen <= 1'b1;
                held <= rdata[15:0];
            end
        end
    end

    always_comb
        for (int i = 0; i < 16; i++)
            m2[2*i+:2] = {2{held[i]}};

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_reset_vals: assert property ($rose(reset_n) |->
        pin_mode_reg == `RST_PIN_MODE && output_type_reg == 16'h0)
        else $error("config not at reset value");
    chk_idle_stable: assert property (!wr |=> $stable(pin_mode_reg) &&
        $stable(output_type_reg) && $stable(altfunc_low_select))
        else $error("config changed without write");
    chk_open_mode: assert property (!touched && wr &&
        addr == `OFF_PIN_MODE |=> pin_mode_reg == $past(wdata))
        else $error("mode write lost with key clear");
    chk_open_otype: assert property (!touched && wr &&
        addr == `OFF_OUTPUT_TYPE |=>
        {16'h0, output_type_reg} == ($past(wdata) & 32'h0000FFFF))
        else $error("output type write lost with key clear");
    chk_key_sticky: assert property (key_seen && lock_rd |->
        rdata[16] && rdata[15:0] == held)
        else $error("lock key or pin locks changed");
    chk_locked_mode: assert property (key_seen && wr |=>
        ((pin_mode_reg ^ $past(pin_mode_reg)) & m2) == 32'h0)
        else $error("locked mode field changed");
    chk_locked_otype: assert property (key_seen && wr |=>
        ((output_type_reg ^ $past(output_type_reg)) & held) == 16'h0)
        else $error("locked output type changed");
    chk_free_pin: assert property (key_seen && wr && !held[1] &&
        addr == `OFF_PIN_MODE |=> pin_mode_reg[3:2] == $past(wdata[3:2]))
        else $error("unlocked pin not writable");
    chk_af_event: assert property (on_a &&
        altfunc_low_select[3:0] == `AF_EVENT |->
        af_valid[0] && af_out[0] == core_event_output)
        else $error("event output not routed");
    chk_af_comp2: assert property (on_a &&
        altfunc_low_select[11:8] == `AF_COMP2 |->
        af_valid[2] && af_out[2] == second_comparator_out)
        else $error("second comparator not routed");
    chk_af_buzzer: assert property (on_a &&
        altfunc_low_select[27:24] == `AF_BUZZER |->
        af_valid[6] && af_out[6] == buzzer_positive_out)
        else $error("buzzer output not routed");

    cover property (key_seen && lock_rd);
    cover property (key_seen && wr && addr == `OFF_PIN_MODE);
    cover property (on_a && altfunc_low_select[3:0] == `AF_EVENT);
endmodule

bind gpio_config_lock_altfunc gpio_lock_checker i_chk
(
    .clk, .reset_n, .port_id, .addr, .wdata, .wr, .rd, .rdata,
    .core_event_output, .second_comparator_out, .buzzer_positive_out,
    .af_out, .af_valid, .pin_mode_reg, .output_type_reg,
    .altfunc_low_select
);
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench for the port lock block
// assumes package, header and checker compiled first
`timescale 1ns/1ps
`default_nettype none
`include "gpio_lock_consts.svh"

module tb_top;
    logic clk, reset_n, wr, rd;
    logic [1:0] port_id;
    logic [7:0] addr, aux;
    logic [31:0] wdata, rdata, pin_mode_reg, pull_select_reg;
    logic [31:0] altfunc_low_select, altfunc_high_select;
    logic [15:0] pin_in, af_out, af_valid, output_type_reg;
    logic [15:0] slew_rate_reg, drive_strength_reg;
    logic core_event_output, second_comparator_out, third_comparator_out;
    logic buzzer_positive_out, buzzer_negative_out, clock_output_pin;
    logic debug_data_out, test_data_out, calendar_stamp_input;
    logic debug_mode_in, debug_clock_in, debug_data_in, test_reset_n;
    int fails;
    int checked;
    logic [7:0] lk = `OFF_CONFIG_LOCK;
    logic [7:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h24, 8'h20, 8'h28};
    int kind [7] = '{2, 1, 1, 2, 1, 4, 5};
    logic [31:0] rstv [7] = '{32'hFFFFFFFF, 32'h0, 32'h0000FFFF, 32'h0,
        32'h0, 32'h0, 32'h0};
    logic [31:0] v1 [7] = '{32'h12345678, 32'h0000A5A5, 32'h00005A5A,
        32'h87654321, 32'h0000F00F, 32'hCC000804, 32'h09000A09};
    logic [31:0] v2 [7];

    assign {core_event_output, second_comparator_out, third_comparator_out,
        buzzer_positive_out, buzzer_negative_out, clock_output_pin,
        debug_data_out, test_data_out} = aux;

    gpio_config_lock_altfunc i_dut (.*);

    always #5 clk = ~clk;
    always @(posedge clk) aux <= aux + 8'h1D;

    // ----------------------------------------
    // access and compare tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic op(input logic w, input logic r, input logic [7:0] a,
        input logic [31:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        op(1'b0, 1'b1, a, 32'h0);
        rd <= 1'b0;
        wr <= 1'b0;
        @(negedge clk);
        chk(rdata, e);
        @(posedge clk);
    endtask

    task automatic arm(input logic [15:0] p1, input logic [15:0] p2,
        input logic [15:0] p3);
        op(1'b1, 1'b0, lk, {16'h0001, p1});
        op(1'b1, 1'b0, lk, {16'h0000, p2});
        op(1'b1, 1'b0, lk, {16'h0001, p3});
    endtask

    function automatic logic [31:0] lmask(input int k, input logic [15:0] p);
        logic [31:0] m;
        m = 32'h0;
        for (int i = 0; i < 16; i++)
        begin
            if (k == 2) m[2*i+:2] = {2{p[i]}};
            if (k == 1) m[i] = p[i];
            if (k == 4 && i < 8) m[4*i+:4] = {4{p[i]}};
            if (k == 5 && i > 7) m[4*i-32+:4] = {4{p[i]}};
        end
        return m;
    endfunction

    task automatic stop_test();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        logic [31:0] m;
        {clk, reset_n, wr, rd, addr, wdata, port_id, pin_in, aux} = '0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 7; i++) rd_chk(offs[i], rstv[i]);
        rd_chk(lk, 32'h0);
        rd_chk(8'hFC, 32'h0);
        for (int i = 0; i < 7; i++) op(1'b1, 1'b0, offs[i], v1[i]);
        for (int i = 0; i < 7; i++) rd_chk(offs[i], v1[i]);
        repeat (4)
        begin
            @(negedge clk);
            chk({16'h0, af_out & 16'h65C5}, {16'h0, 1'b0, second_comparator_out,
                debug_data_out, 2'b0, third_comparator_out, 1'b0,
                clock_output_pin, buzzer_negative_out, buzzer_positive_out,
                3'b0, second_comparator_out, 1'b0,
                core_event_output});
            chk({16'h0, af_valid & 16'h65C5}, 32'h000065C5);
        end
        @(posedge clk);
        arm(16'hC010, 16'hC011, 16'hC011);
        rd_chk(lk, 32'h0000C011);
        rd_chk(lk, 32'h0000C011);
        op(1'b1, 1'b0, lk, 32'h0001C010);
        op(1'b1, 1'b0, lk, 32'h0000C010);
        rd_chk(lk, 32'h0000C010);
        op(1'b1, 1'b0, lk, 32'h0001C010);
        rd_chk(lk, 32'h0000C010);
        rd_chk(lk, 32'h0000C010);
        arm(16'hC010, 16'hC010, 16'hC010);
        rd_chk(lk, 32'h0000C010);
        rd_chk(lk, 32'h0001C010);
        op(1'b1, 1'b0, lk, 32'h0000FFFF);
        arm(16'h0000, 16'h0000, 16'h0000);
        rd_chk(lk, 32'h0001C010);
        for (int i = 0; i < 7; i++)
        begin
            v2[i] = ~v1[i] & (kind[i] == 1 ? 32'h0000FFFF : 32'hFFFFFFFF);
            op(1'b1, 1'b0, offs[i], v2[i]);
        end
        for (int i = 0; i < 7; i++)
        begin
            m = lmask(kind[i], 16'hC010);
            rd_chk(offs[i], (v1[i] & m) | (v2[i] & ~m));
        end
        reset_n <= 1'b0;
        pin_in <= 16'h4000;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd_chk(lk, 32'h0);
        rd_chk(offs[0], 32'hFFFFFFFF);
        op(1'b1, 1'b0, offs[0], 32'h0);
        rd_chk(offs[0], 32'h0);
        @(negedge clk);
        chk({29'h0, debug_mode_in, debug_clock_in, debug_data_in},
            32'h00000002);
        @(posedge clk);
        port_id <= 2'd2;
        op(1'b1, 1'b0, `OFF_ALTFUNC_HIGH, 32'h99900B00);
        op(1'b1, 1'b0, `OFF_ALTFUNC_LOW, 32'hCC000000);
        wr <= 1'b0;
        @(negedge clk);
        chk({31'h0, calendar_stamp_input}, 32'h00000001);
        chk({16'h0, af_valid}, 32'h00000000);
        @(posedge clk);
        port_id <= 2'd1;
        @(posedge clk);
        @(negedge clk);
        chk({16'h0, af_out}, {21'h0, third_comparator_out, 2'h0,
            buzzer_negative_out, buzzer_positive_out, 2'h0,
            test_data_out, 3'h0});
        chk({16'h0, af_valid}, 32'h000004C8);
        chk({30'h0, calendar_stamp_input, test_reset_n}, 32'h0);
        stop_test();
    end

    initial
    begin
        repeat (2000) @(posedge clk);
        fails++;
        stop_test();
    end
endmodule
`default_nettype wire
